// file: block_ram_pkg.sv
// constants, modes and width helpers for the embedded block ram
// Overview of operation
// - array holds 9 Kbit, registered on input and output sides
// - mode is single port, true dual port or pseudo dual port
// - widths 1,2,4,9,18,36; true dual port stops at 18 bits
// - each port of a multi-port mode uses its own width
// - bits laid out word 0 lsb to msb, then word 1, per port
// - contents may be preloaded while the device is configuring
// - preload plus disabled writes turns the block into a rom
// - address and write data captured at the array on the clock edge
// - read data leaves directly or through an optional output register
package block_ram_pkg;
  localparam int ROW_BITS = 36;
  localparam int ROWS     = 256;
  localparam int ROW_AW   = 8;
  localparam int ADDR_W   = 13;
  localparam int CODE_W   = 3;
  localparam int OFF_W    = 6;
  localparam logic [CODE_W-1:0] W36_CODE = 3'h5;
  localparam logic [CODE_W-1:0] MAX_CODE = 3'h5;
  // wishbone byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // control field layout
  localparam int CTRL_W      = 10;
  localparam int CTRL_MODE   = 0;
  localparam int CTRL_WA     = 2;
  localparam int CTRL_WB     = 5;
  localparam int CTRL_OREG   = 8;
  localparam int CTRL_PROT   = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h094;
  // status field layout
  localparam int STAT_CFGERR = 0;
  localparam int STAT_PROTWR = 1;
  localparam int STAT_INCFG  = 2;

  typedef enum logic [1:0] {
    MODE_SINGLE    = 2'h0,
    MODE_TRUE_DUAL = 2'h1,
    MODE_PSEUDO    = 2'h3,
    MODE_BAD       = 2'h2
  } mode_e;

  // data width of a port width code
  function automatic logic [5:0] width_of(input logic [CODE_W-1:0] code);
    case (code)
      3'h0: width_of = 6'h01;
      3'h1: width_of = 6'h02;
      3'h2: width_of = 6'h04;
      3'h3: width_of = 6'h09;
      3'h4: width_of = 6'h12;
      3'h5: width_of = 6'h24;
      default: width_of = 6'h01;
    endcase
  endfunction

  // words of that width packed in one 36-bit row
  function automatic logic [5:0] per_row_of(input logic [CODE_W-1:0] code);
    case (code)
      3'h0: per_row_of = 6'h24;
      3'h1: per_row_of = 6'h12;
      3'h2: per_row_of = 6'h09;
      3'h3: per_row_of = 6'h04;
      3'h4: per_row_of = 6'h02;
      default: per_row_of = 6'h01;
    endcase
  endfunction
endpackage

// file: block_ram_port.sv
// one port: input registers, bit placement, read path and output register
`timescale 1ns/100ps
`default_nettype none
module block_ram_port (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // user side
  input  wire logic                                en_i,
  input  wire logic                                we_i,
  input  wire logic [block_ram_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [block_ram_pkg::ROW_BITS-1:0]  wdata_i,
  output logic      [block_ram_pkg::ROW_BITS-1:0]  rdata_o,
  output logic                                     rvalid_o,
  // configuration
  input  wire logic [block_ram_pkg::CODE_W-1:0]    code_i,
  input  wire logic                                wr_ok_i,
  input  wire logic                                rd_ok_i,
  input  wire logic                                oreg_i,
  // array side
  block_ram_port_if.port                           ram
);
  import block_ram_pkg::*;

  logic [ADDR_W-1:0]   cap_addr;
  logic [ROW_BITS-1:0] cap_data;
  logic                cap_we;
  logic                cap_rd;
  logic [ROW_BITS-1:0] raw_data;
  logic                raw_valid;
  logic [ROW_BITS-1:0] out_data;
  logic                out_valid;
  logic [5:0]          width;
  logic [5:0]          per_row;
  logic [ADDR_W-1:0]   row_full;
  logic [ADDR_W-1:0]   slot;
  logic [OFF_W-1:0]    off;
  logic [ROW_BITS-1:0] ones;
  logic [ROW_BITS-1:0] field;
  logic                in_range;

  // input registers at the array edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_addr <= '0;
      cap_data <= '0;
      cap_we   <= 1'b0;
      cap_rd   <= 1'b0;
    end else begin
      if (en_i) begin
        cap_addr <= addr_i;
        cap_data <= wdata_i;
      end
      cap_we <= en_i & we_i & wr_ok_i;
      cap_rd <= en_i & ~we_i & rd_ok_i;
    end
  end

  // linear bit layout; every width divides 36, so no word straddles rows
  assign width    = width_of(code_i);
  assign per_row  = per_row_of(code_i);
  assign row_full = cap_addr / ADDR_W'(per_row);
  assign slot     = cap_addr % ADDR_W'(per_row);
  assign off      = OFF_W'(slot * ADDR_W'(width));
  assign ones     = (ROW_BITS'(1) << width) - ROW_BITS'(1);
  assign in_range = row_full < ADDR_W'(ROWS);

  // array requests; x1 leaves the top 1024 bits unreachable
  assign ram.row   = row_full[ROW_AW-1:0];
  assign ram.wmask = ones << off;
  assign ram.wdata = (cap_data & ones) << off;
  assign ram.wr    = cap_we & in_range;
  assign field     = (ram.rrow >> off) & ones;

  // array output latch and optional output register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_data  <= '0;
      raw_valid <= 1'b0;
      out_data  <= '0;
      out_valid <= 1'b0;
    end else begin
      raw_data  <= in_range ? field : '0;
      raw_valid <= cap_rd;
      out_data  <= raw_data;
      out_valid <= raw_valid;
    end
  end

  // mode bit picks the tap; it should not change while reads are in flight
  assign rdata_o  = oreg_i ? out_data : raw_data;
  assign rvalid_o = oreg_i ? out_valid : raw_valid;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence rd_taken_s;
    en_i && !we_i && rd_ok_i;
  endsequence

  rd_direct_a: assert property (rd_taken_s ##2 !oreg_i |-> rvalid_o)
    else $error("direct read not valid two cycles after request");
  rd_oreg_a: assert property (rd_taken_s ##3 oreg_i |-> rvalid_o)
    else $error("registered read not valid three cycles after request");
  addr_cap_a: assert property (en_i |=> cap_addr == $past(addr_i))
    else $error("address not captured on enable");
  mask_width_a: assert property (ram.wr |-> $countones(ram.wmask) == width)
    else $error("write mask does not match port width");
  oreg_data_a: assert property (oreg_i |-> rdata_o == $past(raw_data))
    else $error("output register does not delay array data");
endmodule
`default_nettype wire

// file: block_ram_port_if.sv
// carrier between one port datapath and the shared array
`timescale 1ns/100ps
`default_nettype none
interface block_ram_port_if;
  import block_ram_pkg::*;
  logic [ROW_AW-1:0]   row;
  logic [ROW_BITS-1:0] wmask;
  logic [ROW_BITS-1:0] wdata;
  logic [ROW_BITS-1:0] rrow;
  logic                wr;
  modport port  (output row, wmask, wdata, wr, input rrow);
  modport array (input row, wmask, wdata, wr, output rrow);
endinterface
`default_nettype wire

// file: embedded_block_ram.sv
// embedded block ram: shared array, two ports and a wishbone config slave
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module embedded_block_ram (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // wishbone classic slave
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [3:0]                          wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  // preload during configuration
  input  wire logic                                cfg_active_i,
  input  wire logic                                load_we_i,
  input  wire logic [block_ram_pkg::ROW_AW-1:0]    load_row_i,
  input  wire logic [block_ram_pkg::ROW_BITS-1:0]  load_data_i,
  // port a
  input  wire logic                                a_en_i,
  input  wire logic                                a_we_i,
  input  wire logic [block_ram_pkg::ADDR_W-1:0]    a_addr_i,
  input  wire logic [block_ram_pkg::ROW_BITS-1:0]  a_wdata_i,
  output logic      [block_ram_pkg::ROW_BITS-1:0]  a_rdata_o,
  output logic                                     a_rvalid_o,
  // port b
  input  wire logic                                b_en_i,
  input  wire logic                                b_we_i,
  input  wire logic [block_ram_pkg::ADDR_W-1:0]    b_addr_i,
  input  wire logic [block_ram_pkg::ROW_BITS-1:0]  b_wdata_i,
  output logic      [block_ram_pkg::ROW_BITS-1:0]  b_rdata_o,
  output logic                                     b_rvalid_o
);
  import block_ram_pkg::*;

  logic [CTRL_W-1:0]   ctrl;
  logic [CTRL_W-1:0]   next_ctrl;
  logic                prot_wr;
  logic                next_prot_wr;
  logic [2:0]          status;
  logic [31:0]         next_dat;
  logic                wb_req;
  logic                ctrl_hit;
  logic                stat_hit;
  logic                ctrl_wr;
  logic                stat_clr;
  logic                prot_set;
  mode_e               mode;
  logic [CODE_W-1:0]   code_a;
  logic [CODE_W-1:0]   code_b;
  logic                oreg;
  logic                prot;
  logic                cfg_err;
  logic                run;
  logic                a_wr_ok;
  logic                a_rd_ok;
  logic                b_wr_ok;
  logic                b_rd_ok;
  logic [ROW_BITS-1:0] mem [ROWS];
  logic [ROW_BITS-1:0] a_merge;
  logic [ROW_BITS-1:0] b_base;
  logic [ROW_BITS-1:0] b_merge;

  block_ram_port_if pa ();
  block_ram_port_if pb ();

  // wishbone decode; ack is registered so every access takes one wait
  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ctrl_hit = wb_adr_i[3:2] == CTRL_OFS[3:2];
  assign stat_hit = wb_adr_i[3:2] == STAT_OFS[3:2];
  assign ctrl_wr  = wb_req & wb_we_i & ctrl_hit;
  assign stat_clr = wb_req & wb_we_i & stat_hit & wb_sel_i[0]
                    & wb_dat_i[STAT_PROTWR];

  // byte lanes 0 and 1 cover the ten control bits
  assign next_ctrl[7:0] = (ctrl_wr & wb_sel_i[0]) ? wb_dat_i[7:0]
                                                  : ctrl[7:0];
  assign next_ctrl[9:8] = (ctrl_wr & wb_sel_i[1]) ? wb_dat_i[9:8]
                                                  : ctrl[9:8];

  // a write attempt against a protected array is flagged; set beats clear
  assign prot_set = prot & ~cfg_active_i
                    & ((a_en_i & a_we_i) | (b_en_i & b_we_i));
  assign next_prot_wr = prot_set | (prot_wr & ~stat_clr);

  // read mux; unmapped offsets read zero
  assign status   = {cfg_active_i, prot_wr, cfg_err};
  assign next_dat = ctrl_hit ? 32'(ctrl)
                  : stat_hit ? 32'(status)
                  : 32'h0000_0000;

  // register file and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= CTRL_RST;
      prot_wr  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      prot_wr  <= next_prot_wr;
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? next_dat : wb_dat_o;
    end
  end

  // configuration fields
  assign mode   = mode_e'(ctrl[CTRL_MODE +: 2]);
  assign code_a = ctrl[CTRL_WA +: CODE_W];
  assign code_b = ctrl[CTRL_WB +: CODE_W];
  assign oreg   = ctrl[CTRL_OREG];
  assign prot   = ctrl[CTRL_PROT];

  // illegal mode or width combinations stop both ports
  assign cfg_err = (mode == MODE_BAD) | (code_a > MAX_CODE)
                 | ((mode != MODE_SINGLE) & (code_b > MAX_CODE))
                 | ((mode == MODE_TRUE_DUAL)
                    & ((code_a == W36_CODE) | (code_b == W36_CODE)));
  assign run     = ~cfg_err & ~cfg_active_i;

  // port roles per mode; pseudo mode is a writes, b reads
  assign a_wr_ok = run & ~prot;
  assign a_rd_ok = run & (mode != MODE_PSEUDO);
  assign b_wr_ok = run & ~prot & (mode == MODE_TRUE_DUAL);
  assign b_rd_ok = run & (mode != MODE_SINGLE);

  block_ram_port port_a (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (a_en_i),
    .we_i     (a_we_i),
    .addr_i   (a_addr_i),
    .wdata_i  (a_wdata_i),
    .rdata_o  (a_rdata_o),
    .rvalid_o (a_rvalid_o),
    .code_i   (code_a),
    .wr_ok_i  (a_wr_ok),
    .rd_ok_i  (a_rd_ok),
    .oreg_i   (oreg),
    .ram      (pa.port)
  );

  block_ram_port port_b (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (b_en_i),
    .we_i     (b_we_i),
    .addr_i   (b_addr_i),
    .wdata_i  (b_wdata_i),
    .rdata_o  (b_rdata_o),
    .rvalid_o (b_rvalid_o),
    .code_i   (code_b),
    .wr_ok_i  (b_wr_ok),
    .rd_ok_i  (b_rd_ok),
    .oreg_i   (oreg),
    .ram      (pb.port)
  );

  // row reads; a read of a row being written returns the old bits
  assign pa.rrow = mem[pa.row];
  assign pb.rrow = mem[pb.row];

  // bit merges; when both ports hit one row, b is layered over a
  assign a_merge = (mem[pa.row] & ~pa.wmask) | pa.wdata;
  assign b_base  = (pa.wr && (pa.row == pb.row)) ? a_merge : mem[pb.row];
  assign b_merge = (b_base & ~pb.wmask) | pb.wdata;

  // storage has no reset; preload owns the array while configuring
  always_ff @(posedge clk_i) begin
    if (cfg_active_i && load_we_i) begin
      mem[load_row_i] <= load_data_i;
    end else begin
      if (pa.wr) begin
        mem[pa.row] <= a_merge;
      end
      if (pb.wr) begin
        mem[pb.row] <= b_merge;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence prot_held_s;
    prot && $past(prot);
  endsequence

  rom_hold_a: assert property (prot_held_s |-> !(pa.wr || pb.wr))
    else $error("array written while write protected");
  pseudo_b_a: assert property ((mode == MODE_PSEUDO)
      && $past(mode == MODE_PSEUDO) |-> !pb.wr)
    else $error("port b wrote in pseudo dual port mode");
  preload_a: assert property (cfg_active_i && load_we_i
      |=> mem[$past(load_row_i)] == $past(load_data_i))
    else $error("preload word not stored");
  tdp_width_a: assert property ((mode == MODE_TRUE_DUAL)
      && (code_a == W36_CODE) |-> !a_rd_ok && !a_wr_ok)
    else $error("36-bit port accepted in true dual port mode");
  b_width_a: assert property (pb.wr && $stable(code_b)
      |-> $countones(pb.wmask) == width_of(code_b))
    else $error("port b mask ignores its own width");

  // flag and gating checks; a stopped or configuring block must refuse both ports
  prot_flag_a: assert property (prot_set |=> prot_wr)
    else $error("protected write attempt not flagged");
  cfg_stop_a: assert property (cfg_err || cfg_active_i
      |-> !(a_wr_ok || a_rd_ok || b_wr_ok || b_rd_ok))
    else $error("port enabled during configuration or config error");
  single_b_a: assert property ((mode == MODE_SINGLE)
      |-> !b_wr_ok && !b_rd_ok)
    else $error("port b enabled in single port mode");
  pseudo_roles_a: assert property ((mode == MODE_PSEUDO)
      |-> !a_rd_ok && !b_wr_ok)
    else $error("wrong port roles in pseudo dual port mode");
endmodule
`default_nettype wire

// file: fabric_user.sv
// user logic model that drives one memory port of the block ram
`timescale 1ns/100ps
`default_nettype none
module fabric_user (
  // clock
  input  wire logic                                clk_i,
  // memory port
  output logic                                     en_o,
  output logic                                     we_o,
  output logic      [block_ram_pkg::ADDR_W-1:0]    addr_o,
  output logic      [block_ram_pkg::ROW_BITS-1:0]  wdata_o,
  input  wire logic [block_ram_pkg::ROW_BITS-1:0]  rdata_i,
  input  wire logic                                rvalid_i
);
  import block_ram_pkg::*;

  // idle port at time zero
  initial begin
    en_o = 1'b0;
    we_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end

  // one word per clock, then the enable is lifted
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [ROW_BITS-1:0] d);
    @(posedge clk_i);
    en_o <= 1'b1;
    we_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    en_o <= 1'b0;
    we_o <= 1'b0;
    // released lines show the inverse so stale values cannot match
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // read one word; lat counts cycles from the request cycle, 0 if none
  task automatic rd(input logic [ADDR_W-1:0] a,
                    output logic [ROW_BITS-1:0] d, output int lat);
    @(posedge clk_i);
    en_o <= 1'b1;
    we_o <= 1'b0;
    addr_o <= a;
    @(posedge clk_i);
    en_o <= 1'b0;
    addr_o <= ~a;
    lat = 0;
    d = '0;
    // answer taken at the rising edge that samples rvalid high
    for (int i = 1; i < 8 && lat == 0; i++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        lat = i;
        d = rdata_i;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tb_embedded_block_ram.sv
// self-checking bench for the embedded block ram
`timescale 1ns/100ps
`default_nettype none
module tb_embedded_block_ram;
  import block_ram_pkg::*;
  localparam logic [35:0] V1 = 36'h987654321;
  localparam logic [35:0] V2 = 36'hABCDEF012;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        cfg_active_i, load_we_i;
  logic [7:0]  load_row_i;
  logic [35:0] load_data_i, a_wdata, b_wdata, a_rdata, b_rdata, d;
  logic [12:0] a_addr, b_addr;
  logic        a_en, a_we, a_rvalid, b_en, b_we, b_rvalid;
  int          num_errors, checked, lat;

  embedded_block_ram embedded_block_ram_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cfg_active_i(cfg_active_i), .load_we_i(load_we_i),
    .load_row_i(load_row_i), .load_data_i(load_data_i),
    .a_en_i(a_en), .a_we_i(a_we), .a_addr_i(a_addr), .a_wdata_i(a_wdata),
    .a_rdata_o(a_rdata), .a_rvalid_o(a_rvalid),
    .b_en_i(b_en), .b_we_i(b_we), .b_addr_i(b_addr), .b_wdata_i(b_wdata),
    .b_rdata_o(b_rdata), .b_rvalid_o(b_rvalid));
  fabric_user fabric_user_inst (.clk_i(clk_i), .en_o(a_en), .we_o(a_we),
    .addr_o(a_addr), .wdata_o(a_wdata), .rdata_i(a_rdata),
    .rvalid_i(a_rvalid));
  fabric_user fabric_user_b_inst (.clk_i(clk_i), .en_o(b_en), .we_o(b_we),
    .addr_o(b_addr), .wdata_o(b_wdata), .rdata_i(b_rdata),
    .rvalid_i(b_rvalid));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [35:0] e,
                     input logic [35:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask

  // classic single cycle; request held until ack is sampled at a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("unexpected ack timeout: expected 1, seen %b", wb_ack_o);
      give_verdict();
    end
  endtask

  // main sequence
  initial begin
    num_errors = 0;
    checked = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, cfg_active_i, load_we_i} = 5'h00;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    load_row_i = 8'h00;
    load_data_i = 36'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0, q);
    chk("ctrl reset", 36'(CTRL_RST), {4'h0, q});
    wb(1'b0, 4'h8, 32'h0, q);
    chk("unmapped read", 36'h0, {4'h0, q});
    // preload one row while configuring; user ports stay inert meanwhile
    @(posedge clk_i);
    cfg_active_i <= 1'b1;
    load_we_i <= 1'b1;
    load_row_i <= 8'h05;
    load_data_i <= V1;
    @(posedge clk_i);
    load_we_i <= 1'b0;
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk("status cfg", 36'h4, {4'h0, q});
    cfg_active_i <= 1'b0;
    fabric_user_inst.rd(13'h0005, d, lat);
    chk("preload data", V1, d);
    chk("latency direct", 36'h2, 36'(lat));
    fabric_user_inst.wr(13'h0007, V2);
    fabric_user_inst.rd(13'h0007, d, lat);
    chk("write back", V2, d);
    wb(1'b1, CTRL_OFS, 32'h194, q);
    fabric_user_inst.rd(13'h0005, d, lat);
    chk("latency oreg", 36'h3, 36'(lat));
    // write protect turns the block into a rom
    wb(1'b1, CTRL_OFS, 32'h294, q);
    fabric_user_inst.wr(13'h0005, ~V1);
    fabric_user_inst.rd(13'h0005, d, lat);
    chk("rom data", V1, d);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk("status protwr", 36'h2, {4'h0, q});
    wb(1'b1, STAT_OFS, 32'h2, q);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk("status clear", 36'h0, {4'h0, q});
    // pseudo dual: a writes x36, b reads x9 from the same row
    wb(1'b1, CTRL_OFS, 32'h077, q);
    fabric_user_inst.wr(13'h0003, V2);
    fabric_user_b_inst.rd(13'h000D, d, lat);
    chk("pseudo x9", (V2 >> 9) & 36'h1FF, d);
    // true dual: b writes x18, a reads x4 inside it
    wb(1'b1, CTRL_OFS, 32'h089, q);
    fabric_user_b_inst.wr(13'h0001, 36'h2ABCD);
    fabric_user_inst.rd(13'h0005, d, lat);
    chk("dual x4", (36'h2ABCD >> 2) & 36'hF, d);
    // true dual: b writes x2 word 3 (bits 7:6), a reads them as x1
    wb(1'b1, CTRL_OFS, 32'h021, q);
    fabric_user_b_inst.wr(13'h0003, 36'h2);
    fabric_user_inst.rd(13'h0007, d, lat);
    chk("dual x1 high", 36'h1, d);
    fabric_user_inst.rd(13'h0006, d, lat);
    chk("dual x1 low", 36'h0, d);
    // width code 6 is not a legal width
    wb(1'b1, CTRL_OFS, 32'h018, q);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk("width code 6", 36'h1, {4'h0, q});
    // illegal mode and a too-wide true dual port are flagged
    wb(1'b1, CTRL_OFS, 32'h096, q);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk("bad mode", 36'h1, {4'h0, q});
    wb(1'b1, CTRL_OFS, 32'h015, q);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk("dual x36", 36'h1, {4'h0, q});
    give_verdict();
  end
endmodule
`default_nettype wire
